// ==== verilog/sac_regs.svh ====
/*
  Constants of the converter control block: register offsets, field
  positions, reset values and timing counts.
  Assumes a 100 MHz system clock and byte addresses on a 32-bit APB.
*/
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// ------------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------------
`define SAC_CLK_PERIOD_NS 10
`define SAC_CONV_TIME_NS 273
`define SAC_CONV_CYCLES (`SAC_CONV_TIME_NS / `SAC_CLK_PERIOD_NS)
`define SAC_RESET_PHASE_NS 1000
`define SAC_RESET_PHASE_CYCLES (`SAC_RESET_PHASE_NS / `SAC_CLK_PERIOD_NS)
`define SAC_POWERDOWN_NS 100000
`define SAC_POWERDOWN_CYCLES (`SAC_POWERDOWN_NS / `SAC_CLK_PERIOD_NS)
`define SAC_INIT_CONVERSIONS 3'h4

// ------------------------------------------------------------------
// Codes
// ------------------------------------------------------------------
`define SAC_ABORT_CODE 14'h3F80

// ------------------------------------------------------------------
// Register map
// ------------------------------------------------------------------
`define SAC_REG_CTRL 8'h00
`define SAC_REG_STATUS 8'h04
`define SAC_REG_RESULT 8'h08
`define SAC_CTRL_CYCLES_W 5
`define SAC_CTRL_RESET 5'h1B
`define SAC_STAT_BUSY 0
`define SAC_STAT_SAMPLING 1
`define SAC_STAT_NAP 2
`define SAC_STAT_RESET 3
`define SAC_STAT_POWERDOWN 4
`define SAC_STAT_VALID 5
`define SAC_STAT_ABORT 6
`define SAC_STAT_INIT_LSB 8

`endif

// ==== verilog/sac_pkg.sv ====
/*
  Types shared by the converter control block.
  Assumes the constants header is compiled alongside it.
*/
package sac_pkg;

  // ----------------------------------------------------------------
  // Control states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT,
    ST_NAP,
    ST_RESET,
    ST_POWERDOWN
  } sac_state_t;

  // ----------------------------------------------------------------
  // Host-side pins, active-low ones as they appear on the pins
  // ----------------------------------------------------------------
  typedef struct packed {
    logic convertStrobeN; // Convert strobe.
    logic selectN;        // Device select.
    logic readN;          // Read strobe.
    logic byteFold;       // Byte-fold select.
    logic napRequestN;    // Nap request.
  } sac_pins_t;

  // ----------------------------------------------------------------
  // Data bus drive
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [13:0] data; // Value driven on the bus.
    logic oe;          // High while the bus is driven.
  } sac_bus_t;

endpackage

// ==== verilog/sac_control.sv ====
/*
  Digital control of a 14-bit successive-approximation converter with
  a parallel result port, plus an APB slave for setup and status.
  Assumes host pins are asynchronous to the clock, the analog front end
  delivers its code in the clock domain, and the testbench resolves the
  three-state result bus from its enable.
*/
`timescale 1ns/1ps
`include "sac_regs.svh"

module sac_control #(
  parameter int RESET_PHASE_CYCLES = `SAC_RESET_PHASE_CYCLES,
  parameter int POWERDOWN_CYCLES = `SAC_POWERDOWN_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire sac_pkg::sac_pins_t hostPins,
  input wire logic sleep_reset_n,
  input wire logic [13:0] analogCode,
  output sac_pkg::sac_bus_t resultBus,
  output logic busy,
  output logic napActive,
  output logic poweredDown,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import sac_pkg::*;

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    sac_state_t state;    // Control state.
    logic [4:0] convCnt;  // Cycles spent converting.
    logic [23:0] rstCnt;  // Cycles spent with powerdown/reset low.
    logic [13:0] held;    // Code captured at the end of sampling.
    logic [13:0] result;  // Output latch.
    logic busyTail;       // Busy kept one cycle past the internal end.
    logic [2:0] initCnt;  // Conversions completed since reset, held at four.
    logic abortSeen;      // Last conversion was aborted.
    sac_pins_t pinMeta;   // First synchroniser stage.
    sac_pins_t pinSync;   // Second synchroniser stage.
    sac_pins_t pinPrev;   // Synchronised pins, one cycle older.
    logic [4:0] convCycles; // Conversion length set by software.
    logic [31:0] rdData;  // Read data captured in the setup cycle.
    logic rdErr;          // Unmapped address seen in the setup cycle.
    sac_bus_t bus;        // Registered bus drive.
  } sac_core_t;

  sac_core_t cur;          // Registered state.
  sac_core_t next_cur;     // Next state.
  logic [1:0] pwdSync;     // Powerdown/reset synchroniser.
  logic pwdAsync;          // Asynchronous entry into reset.
  logic pwdActive;         // Powerdown/reset held, in clock domain.
  logic cvRise;            // Convert strobe went high.
  logic cvFall;            // Convert strobe went low.
  logic csFall;            // Device select went low.
  logic cvHigh;            // Convert strobe level.
  logic csLow;             // Device select level.
  logic startSample;       // A sampling start is requested.
  logic startConvert;      // A conversion start is requested.
  logic convEnd;           // Internal end of conversion.
  logic apbSetup;          // APB setup cycle.
  logic apbWrite;          // APB write takes effect this edge.
  logic [31:0] statusWord; // Status register contents.

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Keeps the conversion length within one cycle and the 273 ns bound.
  function automatic logic [4:0] clampCycles(input logic [31:0] v);
    logic [4:0] lim;
    lim = 5'(`SAC_CONV_CYCLES);
    if (v == 32'h0000_0000) begin
      return 5'h01;
    end
    if (v > 32'(lim)) begin
      return lim;
    end
    return v[4:0];
  endfunction

  // True for an address that holds a register.
  function automatic logic mapped(input logic [7:0] a);
    return (a == `SAC_REG_CTRL) || (a == `SAC_REG_STATUS) ||
      (a == `SAC_REG_RESULT);
  endfunction

  // ----------------------------------------------------------------
  // Powerdown/reset input
  // ----------------------------------------------------------------
  // The pin sets the synchroniser without a clock, so the falling edge
  // takes effect even while the clock is idle; release is synchronous
  // so that no flop leaves reset on a metastable level.
  assign pwdAsync = sys_rst | ~sleep_reset_n;

  // Two-stage synchroniser, preset by the asynchronous entry.
  always_ff @(posedge clock or posedge pwdAsync) begin
    if (pwdAsync) begin
      pwdSync <= 2'b11;
    end else begin
      pwdSync <= {pwdSync[0], 1'b0};
    end
  end

  assign pwdActive = pwdSync[1];

  // ----------------------------------------------------------------
  // Pin events
  // ----------------------------------------------------------------
  // Edges are taken between the second stage and its older copy only.
  assign cvHigh = cur.pinSync.convertStrobeN;
  assign csLow = ~cur.pinSync.selectN;
  assign cvRise = cur.pinSync.convertStrobeN & ~cur.pinPrev.convertStrobeN;
  assign cvFall = ~cur.pinSync.convertStrobeN & cur.pinPrev.convertStrobeN;
  assign csFall = ~cur.pinSync.selectN & cur.pinPrev.selectN;

  // Sampling starts on a strobe rise or a select fall, only while busy is low.
  assign startSample = ((cvRise & csLow) | (csFall & cvHigh)) & ~busy;
  // Conversion starts on a strobe fall or a select fall with strobe low.
  assign startConvert = (cvFall & csLow) | (csFall & ~cvHigh);
  // The internal conversion clock is the system clock; the length is
  // capped at the cycle count of 273 ns.
  assign convEnd = (cur.state == ST_CONVERT) &&
    (cur.convCnt == cur.convCycles - 5'h01);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pwrite & mapped(paddr);

  // Status word seen by software.
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`SAC_STAT_BUSY] = busy;
    statusWord[`SAC_STAT_SAMPLING] = (cur.state == ST_SAMPLE);
    statusWord[`SAC_STAT_NAP] = napActive;
    statusWord[`SAC_STAT_RESET] = (cur.state == ST_RESET);
    statusWord[`SAC_STAT_POWERDOWN] = poweredDown;
    statusWord[`SAC_STAT_VALID] = (cur.initCnt == `SAC_INIT_CONVERSIONS);
    statusWord[`SAC_STAT_ABORT] = cur.abortSeen;
    statusWord[`SAC_STAT_INIT_LSB +: 3] = cur.initCnt;
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    // Pins pass two flops; the older copy feeds the edge detectors.
    next_cur.pinMeta = hostPins;
    next_cur.pinSync = cur.pinMeta;
    next_cur.pinPrev = cur.pinSync;
    next_cur.busyTail = 1'b0;

    // Software sets the conversion length.
    if (apbWrite && (paddr == `SAC_REG_CTRL)) begin
      next_cur.convCycles = clampCycles(pwdata);
    end

    // Read data and error are fixed in the setup cycle.
    if (apbSetup) begin
      next_cur.rdErr = ~mapped(paddr);
      unique case (paddr)
        `SAC_REG_CTRL: begin
          next_cur.rdData = {27'h0, cur.convCycles};
        end
        `SAC_REG_STATUS: begin
          next_cur.rdData = statusWord;
        end
        `SAC_REG_RESULT: begin
          next_cur.rdData = {18'h0, cur.result};
        end
        default: begin
          next_cur.rdData = 32'h0000_0000;
        end
      endcase
    end

    if (pwdActive) begin
      // Powerdown/reset low overrides every other state transition.
      unique case (cur.state)
        ST_RESET: begin
          if (cur.rstCnt >= 24'(RESET_PHASE_CYCLES - 1)) begin
            // Beyond the reset phase, keep counting toward powerdown.
            if (cur.rstCnt >= 24'(POWERDOWN_CYCLES - 1)) begin
              next_cur.state = ST_POWERDOWN;
            end else begin
              next_cur.rstCnt = cur.rstCnt + 24'h1;
            end
          end else begin
            next_cur.rstCnt = cur.rstCnt + 24'h1;
          end
        end
        ST_POWERDOWN: begin
          next_cur.state = ST_POWERDOWN;
        end
        default: begin
          // Entering reset aborts any conversion and shows the code.
          next_cur.state = ST_RESET;
          next_cur.rstCnt = 24'h0;
          next_cur.result = `SAC_ABORT_CODE;
          next_cur.initCnt = 3'h0;
          next_cur.abortSeen = 1'b0;
        end
      endcase
    end else begin
      unique case (cur.state)
        ST_RESET, ST_POWERDOWN: begin
          // Release returns to normal operation on the next edge.
          next_cur.state = ST_IDLE;
          next_cur.rstCnt = 24'h0;
        end
        ST_IDLE: begin
          if (startSample) begin
            next_cur.state = ST_SAMPLE;
          end else if (~cur.pinSync.napRequestN && ~busy) begin
            // Nap only once busy is low and nothing is sampling.
            next_cur.state = ST_NAP;
          end
        end
        ST_NAP: begin
          // A new sampling start leaves nap for sampling; raising the request
          // alone drops back to idle.
          if (startSample) begin
            next_cur.state = ST_SAMPLE;
          end else if (cur.pinSync.napRequestN) begin
            next_cur.state = ST_IDLE;
          end else begin
            next_cur.state = ST_NAP;
          end
        end
        ST_SAMPLE: begin
          if (startConvert) begin
            // Hold the input code; the front end may move on.
            next_cur.state = ST_CONVERT;
            next_cur.held = analogCode;
            next_cur.convCnt = 5'h00;
          end
        end
        ST_CONVERT: begin
          if (csFall && cvHigh) begin
            // Aborted conversions leave the abort code in the latch.
            next_cur.state = ST_IDLE;
            next_cur.result = `SAC_ABORT_CODE;
            next_cur.abortSeen = 1'b1;
          end else if (convEnd) begin
            // The latch takes the code as unsigned binary, unchanged.
            next_cur.result = cur.held;
            next_cur.abortSeen = 1'b0;
            next_cur.busyTail = 1'b1;
            if (cur.initCnt != `SAC_INIT_CONVERSIONS) begin
              next_cur.initCnt = cur.initCnt + 3'h1;
            end
            // Armed by strobe high and select low: sample at once,
            // while busy is still showing.
            if (csLow && cvHigh) begin
              next_cur.state = ST_SAMPLE;
            end else begin
              next_cur.state = ST_IDLE;
            end
          end else begin
            next_cur.convCnt = cur.convCnt + 5'h01;
          end
        end
      endcase
    end

    // Bus drive is registered; select and read both low enable it.
    next_cur.bus.oe = ~cur.pinSync.selectN & ~cur.pinSync.readN;
    if (cur.pinSync.byteFold) begin
      next_cur.bus.data = {cur.result[5:0], 8'h00};
    end else begin
      next_cur.bus.data = cur.result;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Constants only under reset; pin levels enter by the clock.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= '{
        state: ST_IDLE,
        convCnt: 5'h00,
        rstCnt: 24'h0,
        held: 14'h0,
        result: `SAC_ABORT_CODE,
        busyTail: 1'b0,
        initCnt: 3'h0,
        abortSeen: 1'b0,
        pinMeta: 5'h1F,
        pinSync: 5'h1F,
        pinPrev: 5'h1F,
        convCycles: `SAC_CTRL_RESET,
        rdData: 32'h0000_0000,
        rdErr: 1'b0,
        bus: '{data: 14'h0, oe: 1'b0}
      };
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Busy spans the conversion and one cycle past its internal end, so
  // a back-to-back sampling start is visible before busy falls.
  assign busy = (cur.state == ST_CONVERT) | cur.busyTail;
  assign napActive = (cur.state == ST_NAP);
  assign poweredDown = (cur.state == ST_POWERDOWN);
  assign resultBus = cur.bus;
  // Zero-wait slave: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign prdata = cur.rdData;
  assign pslverr = psel & penable & cur.rdErr;

endmodule

// ==== testbench/sac_control_props.sv ====
/*
  Concurrent checks on the pins of the converter control block.
  Assumes it is bound to sac_control and sees only that module's ports.
*/
`timescale 1ns/1ps
module sac_control_props (
  input wire logic clock,
  input wire logic sys_rst,
  input wire sac_pkg::sac_pins_t hostPins,
  input wire logic sleep_reset_n,
  input wire sac_pkg::sac_bus_t resultBus,
  input wire logic busy,
  input wire logic napActive,
  input wire logic poweredDown
);
  import sac_pkg::*;
  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  // Pins pass a two-flop synchroniser, so levels are trusted after five edges.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  reset_phase_a: assert property ((!sleep_reset_n)[*3] |-> !busy && !napActive)
    else $error("Busy or nap while held in reset.");
  bus_off_sel_a: assert property (hostPins.selectN[*5] |-> !resultBus.oe)
    else $error("Bus driven while deselected.");
  bus_off_rd_a: assert property (hostPins.readN[*5] |-> !resultBus.oe)
    else $error("Bus driven without read strobe.");
  bus_on_a: assert property ((!hostPins.selectN && !hostPins.readN && sleep_reset_n)[*5]
    |-> resultBus.oe)
    else $error("Bus not driven during a read.");
  fold_low_a: assert property ((resultBus.oe && hostPins.byteFold)[*2]
    |-> resultBus.data[7:0] == 8'h00)
    else $error("Folded read has non-zero low bits.");
  busy_hold_a: assert property ($rose(busy) |-> busy[*8])
    else $error("Busy dropped early in a conversion.");
  conv_bound_a: assert property ($rose(busy) |-> ##[1:32] !busy)
    else $error("Conversion overran its time.");
  power_up_a: assert property ($rose(sleep_reset_n) |-> ##[1:5] !poweredDown)
    else $error("Powerdown not left after release.");
  nap_off_a: assert property (hostPins.napRequestN[*5] |-> !napActive)
    else $error("Nap while the request is inactive.");
  nap_hold_a: assert property ((!hostPins.napRequestN && !hostPins.convertStrobeN
    && sleep_reset_n)[*4] ##0 napActive |=> napActive)
    else $error("Nap left without a sampling start.");
  // The main scenarios must actually occur.
  cover property ($rose(busy));
  cover property ($rose(napActive));
  cover property ($rose(poweredDown));
endmodule
bind sac_control sac_control_props chk (
  .clock(clock), .sys_rst(sys_rst), .hostPins(hostPins), .sleep_reset_n(sleep_reset_n),
  .resultBus(resultBus), .busy(busy), .napActive(napActive), .poweredDown(poweredDown));

// ==== testbench/sac_host_model.sv ====
/*
  Behavioural host that drives the converter's control pins and reads the bus.
  Assumes its tasks are called just after a rising clock edge.
*/
`timescale 1ns/1ps
module sac_host_model (
  input wire logic clock,
  input wire logic busy,
  input wire sac_pkg::sac_bus_t resultBus,
  output sac_pkg::sac_pins_t hostPins,
  output logic [13:0] busLine,
  output logic taken
);
  import sac_pkg::*;
  logic [13:0] lastLine; // Last level seen on the bus.
  initial begin
    hostPins = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h1};
    taken = 1'h0;
    lastLine = 14'h0000;
  end
  // A released bus shows a pattern that flips every cycle, never a stale value.
  assign busLine = resultBus.oe ? resultBus.data : ~lastLine;
  always @(posedge clock) begin
    lastLine <= busLine;
  end
  // ------------------------------------------------------------------
  // Host operations
  // ------------------------------------------------------------------
  // Mode 0 is a plain conversion, 1 starts the next acquisition early, 2 aborts.
  task automatic convert(input int acq, input int mode);
    int k;
    logic seen;
    k = 0;
    seen = 1'h0;
    hostPins.selectN <= 1'h0;
    hostPins.convertStrobeN <= 1'h1;
    // After a nap the acquisition is six cycles longer.
    repeat (acq + (hostPins.napRequestN ? 0 : 6)) @(posedge clock);
    hostPins.convertStrobeN <= 1'h0;
    while (k < 80 && !(seen && !busy)) begin
      @(posedge clock);
      k++;
      if (busy) seen = 1'h1;
      // Strobe goes high during busy and stays so, with select left low in mode 1.
      if (busy && mode != 0) hostPins.convertStrobeN <= 1'h1;
      // A select pulse while busy with the strobe high.
      if (mode == 2) hostPins.selectN <= (k > 2 && k < 12);
    end
    if (mode == 2) hostPins.convertStrobeN <= 1'h0;
  endtask
  // Read with select already low; the value is offered to the bench via taken.
  task automatic read(input logic fold);
    hostPins.readN <= 1'h0;
    hostPins.byteFold <= fold;
    repeat (5) @(posedge clock);
    taken <= 1'h1;
    @(posedge clock);
    taken <= 1'h0;
    hostPins.readN <= 1'h1;
  endtask
  task automatic nap(input logic n);
    hostPins.napRequestN <= n;
  endtask
endmodule

// ==== testbench/sar_adc_parallel_control_test.sv ====
/*
  Self-checking bench of the converter control block.
  Assumes the host model and checker are compiled before it.
*/
`timescale 1ns/1ps
`include "sac_regs.svh"
module sar_adc_parallel_control_test;
  import sac_pkg::*;
  logic clock;
  logic sys_rst;
  logic sleep_reset_n;
  logic [13:0] analogCode;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic busy;
  logic napActive;
  logic poweredDown;
  logic taken;
  logic [13:0] busLine;
  sac_pins_t hostPins;
  sac_bus_t resultBus;
  logic [31:0] exq[$]; // Expected results, oldest first.
  logic [31:0] seed = 32'h000178FB;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #5 clock = ~clock;
  // Short reset and powerdown counts keep the run brief.
  sac_control #(.RESET_PHASE_CYCLES(4), .POWERDOWN_CYCLES(20)) dut (
    .clock(clock), .sys_rst(sys_rst), .hostPins(hostPins), .sleep_reset_n(sleep_reset_n),
    .analogCode(analogCode), .resultBus(resultBus), .busy(busy), .napActive(napActive),
    .poweredDown(poweredDown), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  sac_host_model host (.clock(clock), .busy(busy), .resultBus(resultBus),
    .hostPins(hostPins), .busLine(busLine), .taken(taken));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One idle edge first, so a released request is never raised again in one step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    while (pready !== 1'h1) @(posedge clock);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exq.push_back(e);
    apb(1'h0, a, 32'h0);
  endtask
  task automatic conv(input logic [13:0] c, input int mode, input logic fold);
    analogCode <= c;
    host.convert(8, mode);
    if (mode == 2) exq.push_back({18'h0, `SAC_ABORT_CODE});
    else exq.push_back({18'h0, fold ? {c[5:0], 8'h00} : c});
    host.read(fold);
  endtask
  // Results are compared as they appear, on the bus or on the register port.
  always @(posedge clock) begin
    if ((psel & penable & pready & ~pwrite) === 1'h1) check(prdata, exq.pop_front());
    if (taken === 1'h1) check({18'h0, busLine}, exq.pop_front());
    // Only the three register words answer without an error flag.
    if ((psel & penable & pready) === 1'h1)
      check({31'h0, pslverr}, {31'h0, !(paddr inside {`SAC_REG_CTRL, `SAC_REG_STATUS, `SAC_REG_RESULT})});
  end
  // A hang is cut short and counted as a mismatch.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      end_of_test();
    end
  end
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    clock = 1'h0;
    sys_rst = 1'h1;
    sleep_reset_n = 1'h1;
    analogCode = 14'h0000;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'h0;
    rd(`SAC_REG_CTRL, 32'h0000001B);
    rd(8'h0C, 32'h0);
    apb(1'h1, `SAC_REG_STATUS, 32'hFFFFFFFF);
    rd(`SAC_REG_STATUS, 32'h0);
    rd(`SAC_REG_RESULT, {18'h0, `SAC_ABORT_CODE});
    apb(1'h1, `SAC_REG_CTRL, 32'h0);
    rd(`SAC_REG_CTRL, 32'h00000001);
    apb(1'h1, `SAC_REG_CTRL, 32'h00000040);
    rd(`SAC_REG_CTRL, 32'h0000001B);
    // The first four results are initialisation and are not read.
    repeat (4) host.convert(8, 0);
    rd(`SAC_REG_STATUS, 32'h00000420);
    conv(14'h0000, 0, 1'h0);
    conv(14'h3FFF, 0, 1'h1);
    conv(14'(xs()), 1, 1'h0);
    conv(14'(xs()), 0, 1'h1);
    conv(14'(xs()), 2, 1'h0);
    rd(`SAC_REG_STATUS, 32'h00000460);
    host.nap(1'h0);
    // Let the nap settle so the host sees it and lengthens acquisition.
    repeat (5) @(posedge clock);
    conv(14'(xs()), 0, 1'h0);
    repeat (20) @(posedge clock);
    check({31'h0, napActive}, 32'h1);
    host.nap(1'h1);
    sleep_reset_n <= 1'h0;
    repeat (3) @(posedge clock);
    rd(`SAC_REG_RESULT, {18'h0, `SAC_ABORT_CODE});
    rd(`SAC_REG_STATUS, 32'h00000008);
    check({31'h0, poweredDown}, 32'h0);
    sleep_reset_n <= 1'h1;
    repeat (5) @(posedge clock);
    sleep_reset_n <= 1'h0;
    repeat (30) @(posedge clock);
    check({31'h0, poweredDown}, 32'h1);
    sleep_reset_n <= 1'h1;
    repeat (5) @(posedge clock);
    host.convert(8, 0);
    end_of_test();
  end
endmodule
